// ==== bench/pfc_plant_model.sv ====
// Behavioural ramp comparator and current sense facing the gate logic
`timescale 1ns/1ns
`default_nettype none
module pfc_plant_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       gate_drive,
  input  wire logic       ramp_release,
  input  wire logic [7:0] cross_dly,
  input  wire logic [7:0] peak_dly,
  output logic            crossing,
  output logic            peak
);
  logic [7:0] ramp_q, ramp_d, on_q, on_d;

  // Counters saturate so a long ramp never wraps into a false crossing
  always_comb begin
    ramp_d = ramp_release ? ramp_q + 8'h01 : 8'h00;
    on_d   = gate_drive ? on_q + 8'h01 : 8'h00;
    if (ramp_release && ramp_q == 8'hFF) ramp_d = ramp_q;
    if (gate_drive && on_q == 8'hFF) on_d = on_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_q <= 8'h00;
      on_q   <= 8'h00;
    end else begin
      ramp_q <= ramp_d;
      on_q   <= on_d;
    end
  end

  // Ramp meets the averaged current level after cross_dly cycles
  assign crossing = ramp_release && (ramp_q >= cross_dly);
  // Current climbs while on; a zero delay means no trip
  assign peak = gate_drive && (peak_dly != 8'h00) && (on_q >= peak_dly);
endmodule : pfc_plant_model
`default_nettype wire

// ==== bench/pfc_pwm_gate_protect_logic_tb.sv ====
// Self-checking bench for the boost corrector gate logic
`timescale 1ns/1ns
`default_nettype none
module pfc_pwm_gate_protect_logic_tb
  import pfc_pkg::*;
;
  localparam int P  = 64;
  localparam int MO = 4;
  localparam int MX = 40;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, junk;
  logic [1:0]  htrans;
  cmp_s        cmp_q, cmp_w;
  logic        crossing, peak, glitch, gate_drive, ramp_release, standby;
  logic        current_comp_force, voltage_comp_discharge, gain_cut;
  logic        gain_boost;
  logic [7:0]  cross_dly, peak_dly;
  int          fail_count, samples_checked, base, lo, hi, len, rises, gbad;

  assign cmp_w = cmp_s'({cmp_q[8:1], crossing});

  pfc_gate_logic #(.PERIOD(P), .MIN_OFF(MO), .MAX_ON(MX), .PEAK_FILTER(3))
  u_pfc_gate_logic (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmp_in(cmp_w),
    .peak_current_limit(peak | glitch), .gate_drive(gate_drive),
    .ramp_release(ramp_release), .current_comp_force(current_comp_force),
    .voltage_comp_discharge(voltage_comp_discharge), .gain_cut(gain_cut),
    .gain_boost(gain_boost), .standby(standby), .irq(irq));

  pfc_plant_model u_pfc_plant_model (.hclk(hclk), .hresetn(hresetn),
    .gate_drive(gate_drive), .ramp_release(ramp_release),
    .cross_dly(cross_dly), .peak_dly(peak_dly), .crossing(crossing),
    .peak(peak));

  always #10 hclk = ~hclk;

  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tmo();
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    tally_and_finish();
  endtask : tmo

  // Master never assumes zero wait states, it waits for hready
  task automatic hrdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) tmo();
    end while (hreadyout !== 1'b1);
  endtask : hrdy

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hrdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hrdy();
    rd = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    check(r, exp);
    check(hresp, 1'b0);
  endtask : rd

  function automatic logic obs(input int k);
    case (k)
      0: return gate_drive;
      1: return standby;
      2: return irq;
      3: return gain_cut;
      5: return ramp_release;
      default: return gain_boost;
    endcase
  endfunction : obs

  task automatic waitv(input int k, input logic v, input int n);
    int i;
    i = 0;
    samples_checked++;
    while (obs(k) !== v) begin
      @(negedge hclk);
      i++;
      if (i > n) tmo();
    end
  endtask : waitv

  // Measures one switching cycle from ramp release to ramp release
  task automatic cyc();
    logic pr, pg;
    int   n, s;
    {lo, hi, len, rises, gbad, n, s} = '0;
    pr = 1'b1;
    pg = 1'b0;
    while (s < 2) begin
      @(negedge hclk);
      n++;
      if (n > 3 * P) tmo();
      if (pr === 1'b0 && ramp_release === 1'b1) s++;
      if (s == 1) begin
        len++;
        lo += (ramp_release === 1'b0);
        hi += (gate_drive === 1'b1);
        rises += (gate_drive === 1'b1 && pg === 1'b0);
        gbad += (ramp_release === 1'b0 && gate_drive === 1'b1);
      end
      pr = ramp_release;
      pg = gate_drive;
    end
    check(len, P);
    check(lo, MO);
    check(gbad, 0);
    check(rises <= 1, 1);
    check(hi <= MX, 1);
  endtask : cyc

  initial begin
    {hclk, hresetn, hsel, hwrite, glitch} = '0;
    {haddr, hwdata, htrans, cmp_q, cross_dly, peak_dly} = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge hclk);
    check({gate_drive, ramp_release, standby, current_comp_force,
           voltage_comp_discharge}, 5'h07);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h00000001);
    rd(ADDR_LIMIT, 32'h0000016D);
    rd(ADDR_MASK, 32'h00000000);
    rd(ADDR_EVENT, 32'h00000000);
    rd(8'h14, 32'h00000000);
    @(posedge hclk) cmp_q.brownout_high <= 1'b1;
    waitv(1, 1'b0, P + 10);
    check(current_comp_force, 1'b0);
    cyc();
    base = hi;
    check(hi > 0, 1);
    fork
      cyc();
      begin
        // Glitch must land in the cycle being measured, not the one before
        waitv(5, 1'b0, 2 * P);
        waitv(0, 1'b1, 2 * P);
        @(posedge hclk) glitch <= 1'b1;
        repeat (2) @(posedge hclk);
        glitch <= 1'b0;
      end
    join
    check(hi, base);
    @(posedge hclk) peak_dly <= 8'd5;
    cyc();
    check(hi > 0 && hi < base, 1);
    @(posedge hclk) peak_dly <= 8'd0;
    @(posedge hclk) cross_dly <= 8'hFF;
    cyc();
    check(hi, 0);
    @(posedge hclk) cross_dly <= 8'd0;
    bus(1'b1, ADDR_LIMIT, 32'h0000000A, junk);
    rd(ADDR_LIMIT, 32'h0000000A);
    @(posedge hclk) cmp_q.ovp_soft <= 1'b1;
    cyc();
    cyc();
    check(hi > 0 && hi <= 10, 1);
    @(posedge hclk) cmp_q.ovp_soft <= 1'b0;
    waitv(0, 1'b1, 3 * P);
    @(posedge hclk) cmp_q.ovp_hard <= 1'b1;
    waitv(0, 1'b0, 6);
    cyc();
    check(hi, 0);
    @(posedge hclk) cmp_q.ovp_hard <= 1'b0;
    waitv(1, 1'b0, 2 * P);
    @(posedge hclk) cmp_q.window_high <= 1'b1;
    waitv(3, 1'b1, 6);
    @(posedge hclk) cmp_q.window_high <= 1'b0;
    @(posedge hclk) cmp_q.window_low <= 1'b1;
    waitv(4, 1'b1, 6);
    waitv(3, 1'b0, 6);
    @(posedge hclk) cmp_q.window_low <= 1'b0;
    bus(1'b0, ADDR_EVENT, 32'h00000000, junk);
    bus(1'b1, ADDR_MASK, 32'h00000008, junk);
    @(posedge hclk) cmp_q.open_loop_protect <= 1'b1;
    waitv(1, 1'b1, 6);
    waitv(2, 1'b1, 8);
    check({gate_drive, current_comp_force, voltage_comp_discharge},
          3'h3);
    rd(ADDR_EVENT, 32'h00000008);
    @(negedge hclk);
    check(irq, 1'b0);
    bus(1'b1, ADDR_MASK, 32'h00000000, junk);
    @(posedge hclk) cmp_q.open_loop_protect <= 1'b0;
    waitv(1, 1'b0, P + 10);
    @(posedge hclk) cmp_q.brownout_high <= 1'b0;
    @(posedge hclk) cmp_q.brownout_low <= 1'b1;
    waitv(1, 1'b1, 6);
    @(posedge hclk) cmp_q.brownout_low <= 1'b0;
    repeat (2 * P) @(negedge hclk);
    check(standby, 1'b1);
    @(posedge hclk) cmp_q.brownout_high <= 1'b1;
    waitv(1, 1'b0, P + 10);
    @(posedge hclk) cmp_q.supply_lockout <= 1'b1;
    waitv(1, 1'b1, 6);
    check(gate_drive, 1'b0);
    rd(ADDR_EVENT, 32'h00000030);
    check(irq, 1'b0);
    tally_and_finish();
  end
endmodule : pfc_pwm_gate_protect_logic_tb
`default_nettype wire

// ==== design/comp_filter.sv ====
// Comparator synchroniser with a stable-time filter per bit
`timescale 1ns/1ns
`default_nettype none
module comp_filter #(
  parameter int WIDTH    = 1,
  parameter int FILT_CYC = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYC - 1);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic          s1_q;
      logic          s2_q;
      logic          out_q;
      logic          out_d;
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] cnt_d;

      // Output flips only after the input differs for FILT_CYC cycles
      always_comb begin
        out_d = out_q;
        cnt_d = '0;
        if (s2_q != out_q) begin
          if (cnt_q == CNT_LAST) begin
            out_d = s2_q;
          end else begin
            cnt_d = cnt_q + CW'(1);
          end
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          out_q <= 1'b0;
          cnt_q <= '0;
        end else begin
          s1_q  <= raw[g];
          s2_q  <= s1_q;
          out_q <= out_d;
          cnt_q <= cnt_d;
        end
      end

      assign clean[g] = out_q;
    end
  endgenerate
endmodule : comp_filter
`default_nettype wire

// ==== design/pfc_gate_logic.sv ====
// Gate pulse logic with protection and an AHB-Lite register port
`timescale 1ns/1ns
`default_nettype none
module pfc_gate_logic
  import pfc_pkg::*;
#(
  parameter int PERIOD      = PERIOD_CYC,
  parameter int MIN_OFF     = TOFF_CYC,
  parameter int MAX_ON      = MAX_ON_CYC,
  parameter int PEAK_FILTER = DEGLITCH_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire cmp_s        cmp_in,
  input  wire logic        peak_current_limit,
  output logic             gate_drive,
  output logic             ramp_release,
  output logic             current_comp_force,
  output logic             voltage_comp_discharge,
  output logic             gain_cut,
  output logic             gain_boost,
  output logic             standby,
  output logic             irq
);
  localparam logic [CNT_W-1:0] LAST_CYC = CNT_W'(PERIOD - 1);
  localparam logic [CNT_W-1:0] TOFF_END = CNT_W'(MIN_OFF - 1);
  localparam logic [CNT_W-1:0] ON_MAX   = CNT_W'(MAX_ON);
  // Brownout state resets high, so its edge detector must too
  localparam logic [EV_W-1:0]  COND_RST = EV_W'(1) << EV_BROWNOUT;

  // Synchronised comparator results
  cmp_s cmp;
  logic peak;

  comp_filter #(.WIDTH($bits(cmp_s)), .FILT_CYC(1)) u_cmp_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     (cmp_in),
    .clean   (cmp)
  );

  comp_filter #(.WIDTH(1), .FILT_CYC(PEAK_FILTER)) u_peak_deglitch (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     (peak_current_limit),
    .clean   (peak)
  );

  // Register state
  logic [1:0]       ctrl_q,   ctrl_d;
  logic [CNT_W-1:0] limit_q,  limit_d;
  logic [EV_W-1:0]  ev_q,     ev_d;
  logic [EV_W-1:0]  mask_q,   mask_d;
  logic [31:0]      rdata_d;
  logic             wr_q,     wr_d;
  logic [7:0]       waddr_q,  waddr_d;
  logic             irq_d;

  // Pulse state
  pwm_state_e       state_q,  state_d;
  logic [CNT_W-1:0] cyc_q,    cyc_d;
  logic [CNT_W-1:0] on_cnt_q, on_cnt_d;
  logic             peak_latch_q, peak_latch_d;
  logic             brown_q,  brown_d;
  logic [EV_W-1:0]  cond_q,   cond;
  logic             fault;
  logic [CNT_W-1:0] on_lim;

  // Brownout hysteresis: set below low level, cleared above high
  always_comb begin
    brown_d = brown_q;
    if (cmp.brownout_low) begin
      brown_d = 1'b1;
    end else if (cmp.brownout_high) begin
      brown_d = 1'b0;
    end
  end

  // Any fault parks the pulse logic in standby
  always_comb begin
    fault = cmp.supply_lockout | cmp.open_loop_protect | brown_q
          | ~ctrl_q[CTRL_ENABLE] | ctrl_q[CTRL_STANDBY];
  end

  // Soft over-voltage takes the tighter of the two on-time limits
  always_comb begin
    on_lim = ON_MAX;
    if (cmp.ovp_soft && limit_q < ON_MAX) begin
      on_lim = limit_q;
    end
  end

  always_comb begin
    cyc_d        = (cyc_q == LAST_CYC) ? '0 : cyc_q + CNT_W'(1);
    state_d      = state_q;
    on_cnt_d     = '0;
    peak_latch_d = peak_latch_q | peak;
    if (fault) begin
      state_d = ST_STANDBY;
    end else if (cyc_q == LAST_CYC) begin
      state_d = ST_MIN_OFF;
    end else begin
      case (state_q)
        ST_STANDBY: state_d = ST_STANDBY;
        ST_MIN_OFF: begin
          if (cyc_q == TOFF_END) begin
            state_d = ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (cmp.ramp_crossing_comparator && !peak_latch_q && !peak
              && !cmp.ovp_hard) begin
            state_d = ST_ON;
          end
        end
        ST_ON: begin
          on_cnt_d = on_cnt_q + CNT_W'(1);
          if (peak || cmp.ovp_hard || on_cnt_d >= on_lim) begin
            state_d = ST_HOLD;
          end
        end
        ST_HOLD:    state_d = ST_HOLD;
        default:    state_d = ST_STANDBY;
      endcase
    end
    // Minimum off beats every other input of the latches
    if (state_q == ST_MIN_OFF) begin
      peak_latch_d = 1'b0;
      on_cnt_d     = '0;
    end
  end

  // Raw levels that raise events on their rising edge
  always_comb begin
    cond               = '0;
    cond[EV_PEAK]      = peak;
    cond[EV_OVP_SOFT]  = cmp.ovp_soft;
    cond[EV_OVP_HARD]  = cmp.ovp_hard;
    cond[EV_OPEN_LOOP] = cmp.open_loop_protect;
    cond[EV_BROWNOUT]  = brown_q;
    cond[EV_LOCKOUT]   = cmp.supply_lockout;
  end

  // Bus slave: zero wait states, data registered in the address phase
  logic take;
  logic rd_event;
  always_comb begin
    take     = hsel & hready & htrans[1];
    rd_event = take & ~hwrite & (haddr[7:0] == ADDR_EVENT);
    wr_d     = take & hwrite;
    waddr_d  = take ? haddr[7:0] : waddr_q;
    rdata_d  = hrdata;
    if (take && !hwrite) begin
      rdata_d = '0;
      case (haddr[7:0])
        ADDR_CTRL:   rdata_d[1:0]       = ctrl_q;
        ADDR_LIMIT:  rdata_d[CNT_W-1:0] = limit_q;
        ADDR_STATUS: rdata_d[2:0]       = state_q;
        ADDR_EVENT:  rdata_d[EV_W-1:0]  = ev_q;
        ADDR_MASK:   rdata_d[EV_W-1:0]  = mask_q;
        default:     rdata_d            = '0;
      endcase
      if (haddr[7:0] == ADDR_STATUS) begin
        rdata_d[8]  = gate_drive;
        rdata_d[9]  = peak_latch_q;
        rdata_d[10] = brown_q;
      end
    end
    ctrl_d  = ctrl_q;
    limit_d = limit_q;
    mask_d  = mask_q;
    if (wr_q) begin
      case (waddr_q)
        ADDR_CTRL:  ctrl_d  = hwdata[1:0];
        ADDR_LIMIT: limit_d = hwdata[CNT_W-1:0];
        ADDR_MASK:  mask_d  = hwdata[EV_W-1:0];
        default:    ctrl_d  = ctrl_q;
      endcase
    end
    // A new edge in the read cycle survives the clear
    ev_d  = (rd_event ? '0 : ev_q) | (cond & ~cond_q);
    irq_d = |(ev_d & mask_d);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= CTRL_RST;
      limit_q   <= LIMIT_RST;
      ev_q      <= '0;
      mask_q    <= '0;
      cond_q    <= COND_RST;
      wr_q      <= 1'b0;
      waddr_q   <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      limit_q   <= limit_d;
      ev_q      <= ev_d;
      mask_q    <= mask_d;
      cond_q    <= cond;
      wr_q      <= wr_d;
      waddr_q   <= waddr_d;
      hrdata    <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= irq_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q                <= ST_STANDBY;
      cyc_q                  <= '0;
      on_cnt_q               <= '0;
      peak_latch_q           <= 1'b0;
      brown_q                <= 1'b1;
      gate_drive             <= 1'b0;
      ramp_release           <= 1'b0;
      current_comp_force     <= 1'b1;
      voltage_comp_discharge <= 1'b1;
      gain_cut               <= 1'b0;
      gain_boost             <= 1'b0;
      standby                <= 1'b1;
    end else begin
      state_q                <= state_d;
      cyc_q                  <= cyc_d;
      on_cnt_q               <= on_cnt_d;
      peak_latch_q           <= peak_latch_d;
      brown_q                <= brown_d;
      gate_drive             <= (state_d == ST_ON);
      ramp_release           <= (state_d == ST_RAMP) || (state_d == ST_ON)
                                || (state_d == ST_HOLD);
      current_comp_force     <= fault;
      voltage_comp_discharge <= fault;
      gain_cut               <= ~fault & cmp.window_high;
      gain_boost             <= ~fault & cmp.window_low;
      standby                <= fault;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_lockout_gate: assert property (
    cmp.supply_lockout |=> !gate_drive)
    else $error("gate high under supply lockout");

  chk_hard_ovp_gate: assert property (
    cmp.ovp_hard |=> !gate_drive)
    else $error("gate high above hard over-voltage");

  chk_min_off_gate: assert property (
    (cyc_q < CNT_W'(MIN_OFF)) |-> !gate_drive && !ramp_release)
    else $error("gate or ramp active in minimum off");

  chk_ramp_release: assert property (
    (state_q == ST_MIN_OFF && cyc_q == TOFF_END && !fault)
      |=> ramp_release && !gate_drive)
    else $error("ramp not released after minimum off");

  chk_cross_turn_on: assert property (
    (state_q == ST_RAMP && cmp.ramp_crossing_comparator && !peak
     && !peak_latch_q && !cmp.ovp_hard && !fault && cyc_q != LAST_CYC)
      |=> gate_drive)
    else $error("ramp crossing did not turn gate on");

  chk_max_on_time: assert property (
    gate_drive |-> on_cnt_q < ON_MAX)
    else $error("on-time beyond maximum duty");

  chk_soft_ovp_limit: assert property (
    (gate_drive && $past(cmp.ovp_soft) && cmp.ovp_soft)
      |-> on_cnt_q <= limit_q)
    else $error("soft over-voltage limit exceeded");

  chk_peak_hold: assert property (
    (peak_latch_q && state_q != ST_MIN_OFF) |-> !gate_drive)
    else $error("gate on after peak limit in same cycle");

  chk_min_off_clear: assert property (
    (state_q == ST_MIN_OFF) |=> !peak_latch_q && !gate_drive)
    else $error("latches not cleared by minimum off");

  chk_standby_clamp: assert property (
    fault |=> current_comp_force && standby && !gate_drive)
    else $error("standby did not clamp current node");

  chk_brown_hyst: assert property (
    (brown_q && !cmp.brownout_high) |=> brown_q)
    else $error("brownout left without high level");

  chk_period_wrap: assert property (
    (cyc_q == LAST_CYC && !fault) |=> state_q == ST_MIN_OFF && cyc_q == 0)
    else $error("switching period did not restart");

  chk_gate_only_on: assert property (
    gate_drive |-> state_q == ST_ON)
    else $error("gate high outside on state");

  chk_standby_quiet: assert property (
    standby |-> !gate_drive && !ramp_release)
    else $error("gate or ramp active in standby");

  chk_open_loop_stby: assert property (
    cmp.open_loop_protect |=> standby && current_comp_force)
    else $error("open loop did not enter standby");

  chk_window_cut: assert property (
    (cmp.window_high && !fault) |=> gain_cut)
    else $error("gain not cut above window");

  chk_window_boost: assert property (
    (cmp.window_low && !fault) |=> gain_boost)
    else $error("gain not boosted below window");

  chk_peak_latch_set: assert property (
    (peak && state_q != ST_MIN_OFF) |=> peak_latch_q)
    else $error("peak limit not latched");

  chk_brown_enter: assert property (
    cmp.brownout_low |=> brown_q)
    else $error("brownout low level not latched");

  chk_irq_level: assert property (
    irq == |(ev_q & mask_q))
    else $error("interrupt does not follow masked events");

  chk_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus slave stalled or signalled error");

  cov_gate_on: cover property (state_q == ST_RAMP ##1 gate_drive);
  cov_peak_trip: cover property (gate_drive ##1 peak_latch_q);
  cov_irq: cover property (irq ##1 rd_event);
  cov_standby_exit: cover property (standby ##1 !standby);
endmodule : pfc_gate_logic
`default_nettype wire

// ==== include/pfc_pkg.sv ====
// Constants, types and register map of the boost corrector gate logic
// What this block does
// - Open-loop sense low shuts block into standby
// - First over-voltage shortens on-time at once
// - Second over-voltage forces gate off at once
// - Fixed internal switching period, nominal 65 kHz
// - Cycle opens with gate off, ramp discharged
// - Ramp released when minimum off ends
// - Ramp crossing current level turns gate on
// - Gate on-time capped at 95 percent
// - Peak limit kills gate for rest of cycle
// - Minimum off clears both latches, top priority
// - Feedback outside window adjusts gain stage directly
// - Gate output is active high
// - Supply lockout holds gate low
// - Standby clamps current compensation node internally
// - Lockout, brownout or open loop mean standby
// - Brownout enters standby with hysteresis
// - Peak limit comparator deglitched 300 ns
package pfc_pkg;

  localparam int CLK_HZ       = 50_000_000;
  localparam int CLK_NS       = 20;
  localparam int SW_HZ        = 65_000;
  localparam int PERIOD_CYC   = CLK_HZ / SW_HZ;
  localparam int TOFF_NS      = 400;
  localparam int TOFF_CYC     = (TOFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEGLITCH_NS  = 300;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_DUTY_PCT = 95;
  localparam int MAX_ON_CYC   = PERIOD_CYC * MAX_DUTY_PCT / 100;
  localparam int CNT_W        = 10;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LIMIT  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVENT  = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;

  // Control fields
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_STANDBY = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [CNT_W-1:0] LIMIT_RST = CNT_W'(MAX_ON_CYC / 2);

  // Event bits, shared by event and mask registers
  localparam int EV_W         = 6;
  localparam int EV_PEAK      = 0;
  localparam int EV_OVP_SOFT  = 1;
  localparam int EV_OVP_HARD  = 2;
  localparam int EV_OPEN_LOOP = 3;
  localparam int EV_BROWNOUT  = 4;
  localparam int EV_LOCKOUT   = 5;

  // Comparator results, one when the condition holds
  typedef struct packed {
    logic supply_lockout;
    logic open_loop_protect;
    logic ovp_soft;
    logic ovp_hard;
    logic window_high;
    logic window_low;
    logic brownout_low;
    logic brownout_high;
    logic ramp_crossing_comparator;
  } cmp_s;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_MIN_OFF,
    ST_RAMP,
    ST_ON,
    ST_HOLD
  } pwm_state_e;

endpackage : pfc_pkg
